//--- core/fsbd_bus_cycle.sv
// Drives one asynchronous flash write or read cycle on the pins per request.
`timescale 1ns/100ps
`default_nettype none
`include "fsbd_consts.svh"

module fsbd_bus_cycle
  import fsbd_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  fsbd_cyc_if.slave              cyc,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [15:0]            flash_dq_o,
  output logic                   flash_dq_oe,
  input  wire logic [15:0]       flash_dq_i
);

  typedef struct packed {
    fsbd_phase_e       ph;
    logic [15:0]       cnt;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
    logic [15:0]       sync1;
    logic [15:0]       sync2;
    logic [15:0]       rdata;
    logic              done;
  } fsbd_cyc_s;

  fsbd_cyc_s cyc_r;
  fsbd_cyc_s cyc_nxt;

  always_comb begin
    cyc_nxt       = cyc_r;
    cyc_nxt.done  = 1'b0;
    cyc_nxt.sync1 = flash_dq_i;
    cyc_nxt.sync2 = cyc_r.sync1;
    unique case (cyc_r.ph)
      FSBD_PH_IDLE: begin
        if (cyc.req) begin
          cyc_nxt.ph    = FSBD_PH_ACT;
          cyc_nxt.wr    = cyc.wr;
          cyc_nxt.addr  = cyc.addr;
          cyc_nxt.wdata = cyc.wdata;
          cyc_nxt.cnt   = cyc.wr ? `FSBD_ACT_CYC : `FSBD_RD_CYC;
        end
      end
      FSBD_PH_ACT: begin
        cyc_nxt.cnt = cyc_r.cnt - 16'h0001;
        if (cyc_r.cnt == 16'h0001) begin
          // The read data has crossed both synchroniser stages by now.
          if (!cyc_r.wr) begin
            cyc_nxt.rdata = cyc_r.sync2;
          end
          cyc_nxt.ph  = FSBD_PH_REC;
          cyc_nxt.cnt = `FSBD_REC_CYC;
        end
      end
      FSBD_PH_REC: begin
        cyc_nxt.cnt = cyc_r.cnt - 16'h0001;
        if (cyc_r.cnt == 16'h0001) begin
          cyc_nxt.ph   = FSBD_PH_IDLE;
          cyc_nxt.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= '0;
    end else begin
      cyc_r <= cyc_nxt;
    end
  end

  assign cyc.ready   = (cyc_r.ph == FSBD_PH_IDLE);
  assign cyc.done    = cyc_r.done;
  assign cyc.rdata   = cyc_r.rdata;
  assign flash_ce_n  = (cyc_r.ph != FSBD_PH_ACT);
  assign flash_we_n  = !((cyc_r.ph == FSBD_PH_ACT) && cyc_r.wr);
  assign flash_oe_n  = !((cyc_r.ph == FSBD_PH_ACT) && !cyc_r.wr);
  assign flash_addr  = cyc_r.addr;
  assign flash_dq_o  = cyc_r.wdata;
  assign flash_dq_oe = (cyc_r.ph != FSBD_PH_IDLE) && cyc_r.wr;

endmodule : fsbd_bus_cycle

`default_nettype wire

//--- core/fsbd_consts.svh
// Command words, unlock offsets and cycle timing shared by the host-side flash command engine.
`ifndef FSBD_CONSTS_SVH
`define FSBD_CONSTS_SVH

`define FSBD_OFS_W          12
`define FSBD_OFS_UNLK_A     12'h555
`define FSBD_OFS_UNLK_B     12'h2AA
`define FSBD_D_UNLK_A       16'h00AA
`define FSBD_D_UNLK_B       16'h0055
`define FSBD_D_BYP_ENTER    16'h0020
`define FSBD_D_BYP_PROG     16'h00A0
`define FSBD_D_SUSPEND      16'h00B0
`define FSBD_D_RESUME       16'h0030
`define FSBD_D_BYP_EXIT1    16'h0090
`define FSBD_D_BYP_EXIT2    16'h0000
`define FSBD_D_RESET        16'h00F0
`define FSBD_ACCEL_MAX_USES 4'hA

`define FSBD_CLK_NS         16'h000A
`define FSBD_T_ACT_NS       16'h0028
`define FSBD_T_REC_NS       16'h001E
`define FSBD_T_RD_NS        16'h0046
`define FSBD_ACT_CYC        ((`FSBD_T_ACT_NS + `FSBD_CLK_NS - 16'h0001) / `FSBD_CLK_NS)
`define FSBD_REC_CYC        ((`FSBD_T_REC_NS + `FSBD_CLK_NS - 16'h0001) / `FSBD_CLK_NS)
`define FSBD_RD_CYC         ((`FSBD_T_RD_NS + `FSBD_CLK_NS - 16'h0001) / `FSBD_CLK_NS + 16'h0002)

`endif

//--- core/fsbd_cyc_if.sv
// Single word cycle request and completion between the command engine and the pin driver.
`timescale 1ns/100ps
`default_nettype none

interface fsbd_cyc_if #(
  parameter int ADDR_W = 24
);
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [15:0]       wdata;
  logic              ready;
  logic              done;
  logic [15:0]       rdata;

  modport master (output req, output wr, output addr, output wdata,
                  input ready, input done, input rdata);
  modport slave  (input req, input wr, input addr, input wdata,
                  output ready, output done, output rdata);
endinterface : fsbd_cyc_if

`default_nettype wire

//--- core/fsbd_host.sv
// Host-side controller issuing suspend, resume, bypass and accelerated-program command sequences.
`timescale 1ns/100ps
`default_nettype none
`include "fsbd_consts.svh"

// What the document requires of this block and the device
// RL1: Suspend word written while programming runs.
// RL2: Resume word written while program suspended.
// RL3: Device halts program within suspend latency.
// RL4: Reads allowed from non-suspended sectors while suspended.
// RL5: Extra resumes refused; suspend allowed after resume.
// RL6: Device accelerates program and erase under voltage.
// RL7: High voltage puts device into bypass mode.
// RL8: Device accepts buffer load in accelerated bypass.
// RL9: Abort reset in bypass uses full three cycles.
// RL10: Dropping voltage after completion restores normal mode.
// RL11: Sectors unlocked before raising the voltage.
// RL12: At most ten accelerated operations per sector.
// RL13: Bypass word program needs only two writes.
// RL14: Bypass entry is AA, 55, 20 in order.
// RL15: Bypass program is A0 then data.
// RL16: Bypass accepts only read, program, reset; here suspend and resume are also legal in bypass while a program runs.
// RL17: Bypass exit is 90 at bank, then 00.
// RL18: Bank returns to array read after exit.
// RL19: Other commands in bypass ignored, mode kept.
module fsbd_host
  import fsbd_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int SECT_W = 4
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire fsbd_op_e          cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [15:0]       cmd_data,
  output logic                   rsp_valid,
  output logic [15:0]            rsp_data,
  output logic                   cmd_refused,
  input  wire logic              accel_req,
  input  wire logic              sectors_unlocked,
  input  wire logic              prog_done,
  output logic                   high_voltage_level,
  output logic                   bypass_mode,
  output logic                   prog_active,
  output logic                   prog_suspended,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [15:0]            flash_dq_o,
  output logic                   flash_dq_oe,
  input  wire logic [15:0]       flash_dq_i
);

  localparam int NSECT = 1 << SECT_W;

  if (ADDR_W < `FSBD_OFS_W + SECT_W || SECT_W < 1) begin : g_bad_widths
    $error("fsbd_host: address too narrow for unlock offsets and sector index");
  end

  typedef struct packed {
    fsbd_state_e                st;
    fsbd_op_e                   op;
    logic [ADDR_W-1:0]          addr;
    logic [15:0]                wdata;
    logic [1:0]                 step;
    logic                       hv;
    logic                       bypass;
    logic                       prog;
    logic                       susp;
    logic                       rsp_valid;
    logic [15:0]                rsp_data;
    logic                       refused;
    logic [NSECT-1:0][3:0]      uses;
  } fsbd_host_s;

  fsbd_host_s h_r;
  fsbd_host_s h_nxt;

  fsbd_cyc_if #(.ADDR_W(ADDR_W)) cyc ();

  // Number of pin cycles each command needs.
  function automatic logic [1:0] seq_len(input fsbd_op_e op);
    unique case (op)
      FSBD_OP_BYP_ENTER, FSBD_OP_ABORT_RESET: seq_len = 2'h3;
      FSBD_OP_BYP_PROG, FSBD_OP_BYP_EXIT:     seq_len = 2'h2;
      default:                                seq_len = 2'h1;
    endcase
  endfunction : seq_len

  function automatic logic [ADDR_W-1:0] unlk(input logic [ADDR_W-1:0] base,
                                             input logic [`FSBD_OFS_W-1:0] ofs);
    unlk = {base[ADDR_W-1:`FSBD_OFS_W], ofs};
  endfunction : unlk

  // Address of pin cycle step of a command sequence.
  function automatic logic [ADDR_W-1:0] seq_addr(input fsbd_op_e op, input logic [1:0] step,
                                                 input logic [ADDR_W-1:0] base);
    seq_addr = base;
    if (op == FSBD_OP_BYP_ENTER || op == FSBD_OP_ABORT_RESET) begin
      seq_addr = unlk(base, (step == 2'h1) ? `FSBD_OFS_UNLK_B : `FSBD_OFS_UNLK_A);
    end
  endfunction : seq_addr

  // Data word of pin cycle step of a command sequence.
  function automatic logic [15:0] seq_data(input fsbd_op_e op, input logic [1:0] step,
                                           input logic [15:0] user);
    seq_data = user;
    unique case (op)
      FSBD_OP_SUSPEND: seq_data = `FSBD_D_SUSPEND; // [RL1]
      FSBD_OP_RESUME:  seq_data = `FSBD_D_RESUME; // [RL2]
      FSBD_OP_BYP_ENTER, FSBD_OP_ABORT_RESET: begin
        if (step == 2'h0) begin
          seq_data = `FSBD_D_UNLK_A; // [RL14] [RL9]
        end else if (step == 2'h1) begin
          seq_data = `FSBD_D_UNLK_B;
        end else begin
          seq_data = (op == FSBD_OP_BYP_ENTER) ? `FSBD_D_BYP_ENTER : `FSBD_D_RESET;
        end
      end
      FSBD_OP_BYP_PROG: seq_data = (step == 2'h0) ? `FSBD_D_BYP_PROG : user; // [RL13] [RL15]
      FSBD_OP_BYP_EXIT: seq_data = (step == 2'h0) ? `FSBD_D_BYP_EXIT1 : `FSBD_D_BYP_EXIT2; // [RL17]
      default:          seq_data = user;
    endcase
  endfunction : seq_data

  function automatic logic [SECT_W-1:0] sect_of(input logic [ADDR_W-1:0] a);
    sect_of = a[ADDR_W-1 -: SECT_W];
  endfunction : sect_of

  logic cmd_legal;

  always_comb begin
    unique case (cmd_op)
      FSBD_OP_READ:        cmd_legal = 1'b1; // [RL4] [RL16]
      FSBD_OP_SUSPEND:     cmd_legal = h_r.prog && !h_r.susp; // [RL1] [RL5]
      FSBD_OP_RESUME:      cmd_legal = h_r.susp; // [RL2] [RL5]
      FSBD_OP_BYP_ENTER:   cmd_legal = !h_r.bypass && !h_r.prog; // [RL19]
      FSBD_OP_BYP_PROG:    cmd_legal = h_r.bypass && !h_r.prog &&
                                       (!h_r.hv || h_r.uses[sect_of(cmd_addr)] <
                                        `FSBD_ACCEL_MAX_USES); // [RL12] [RL16]
      FSBD_OP_BYP_EXIT:    cmd_legal = h_r.bypass && !h_r.hv && !h_r.prog; // [RL16]
      FSBD_OP_ABORT_RESET: cmd_legal = h_r.bypass; // [RL9]
      default:             cmd_legal = 1'b0; // [RL19]
    endcase
  end

  always_comb begin
    h_nxt           = h_r;
    h_nxt.rsp_valid = 1'b0;
    h_nxt.refused   = 1'b0;
    if (prog_done && h_r.prog) begin
      h_nxt.prog = 1'b0;
      h_nxt.susp = 1'b0;
    end
    unique case (h_r.st)
      FSBD_ST_IDLE: begin
        if (accel_req && !h_r.hv && sectors_unlocked && !h_r.prog && !h_r.bypass) begin
          h_nxt.hv     = 1'b1; // [RL11]
          h_nxt.bypass = 1'b1; // [RL7]
        end else if (!accel_req && h_r.hv && !h_r.prog) begin
          h_nxt.hv     = 1'b0; // [RL10]
          h_nxt.bypass = 1'b0;
        end else if (cmd_valid) begin
          if (cmd_legal) begin
            h_nxt.st    = FSBD_ST_ISSUE;
            h_nxt.op    = cmd_op;
            h_nxt.addr  = cmd_addr;
            h_nxt.wdata = cmd_data;
            h_nxt.step  = 2'h0;
          end else begin
            h_nxt.refused = 1'b1; // [RL19]
          end
        end
      end
      FSBD_ST_ISSUE: begin
        if (cyc.ready) begin
          h_nxt.st = FSBD_ST_WAIT;
        end
      end
      FSBD_ST_WAIT: begin
        if (cyc.done) begin
          if (h_r.step + 2'h1 < seq_len(h_r.op)) begin
            h_nxt.step = h_r.step + 2'h1;
            h_nxt.st   = FSBD_ST_ISSUE;
          end else begin
            h_nxt.st = FSBD_ST_IDLE;
            unique case (h_r.op)
              FSBD_OP_READ: begin
                h_nxt.rsp_valid = 1'b1;
                h_nxt.rsp_data  = cyc.rdata;
              end
              FSBD_OP_SUSPEND:     h_nxt.susp = 1'b1; // [RL3]
              FSBD_OP_RESUME:      h_nxt.susp = 1'b0; // [RL5]
              FSBD_OP_BYP_ENTER:   h_nxt.bypass = 1'b1; // [RL14]
              FSBD_OP_BYP_PROG: begin
                h_nxt.prog = 1'b1; // [RL15]
                if (h_r.hv) begin
                  h_nxt.uses[sect_of(h_r.addr)] = h_r.uses[sect_of(h_r.addr)] + 4'h1; // [RL12]
                end
              end
              FSBD_OP_BYP_EXIT:    h_nxt.bypass = 1'b0; // [RL18]
              FSBD_OP_ABORT_RESET: h_nxt.prog = 1'b0; // [RL9]
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign cyc.req   = (h_r.st == FSBD_ST_ISSUE);
  assign cyc.wr    = (h_r.op != FSBD_OP_READ);
  assign cyc.addr  = seq_addr(h_r.op, h_r.step, h_r.addr);
  assign cyc.wdata = seq_data(h_r.op, h_r.step, h_r.wdata);

  fsbd_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clock       (clock),
    .rst_n       (rst_n),
    .cyc         (cyc.slave),
    .flash_ce_n  (flash_ce_n),
    .flash_we_n  (flash_we_n),
    .flash_oe_n  (flash_oe_n),
    .flash_addr  (flash_addr),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_dq_i  (flash_dq_i)
  );

  assign cmd_ready          = (h_r.st == FSBD_ST_IDLE);
  assign rsp_valid          = h_r.rsp_valid;
  assign rsp_data           = h_r.rsp_data;
  assign cmd_refused        = h_r.refused;
  assign high_voltage_level = h_r.hv;
  assign bypass_mode        = h_r.bypass;
  assign prog_active        = h_r.prog;
  assign prog_suspended     = h_r.susp;

endmodule : fsbd_host

`default_nettype wire

//--- core/fsbd_pkg.sv
// Types shared by the host-side flash command engine and its bus cycle generator.
package fsbd_pkg;

  typedef enum logic [2:0] {
    FSBD_OP_READ,
    FSBD_OP_SUSPEND,
    FSBD_OP_RESUME,
    FSBD_OP_BYP_ENTER,
    FSBD_OP_BYP_PROG,
    FSBD_OP_BYP_EXIT,
    FSBD_OP_ABORT_RESET
  } fsbd_op_e;

  typedef enum logic [1:0] {
    FSBD_ST_IDLE,
    FSBD_ST_ISSUE,
    FSBD_ST_WAIT
  } fsbd_state_e;

  typedef enum logic [1:0] {
    FSBD_PH_IDLE,
    FSBD_PH_ACT,
    FSBD_PH_REC
  } fsbd_phase_e;

endpackage : fsbd_pkg

//--- tb/fsbd_flash_model.sv
// Behavioural flash bank that logs host write words and answers array reads.
`timescale 1ns/100ps
`default_nettype none

module fsbd_flash_model (
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic [23:0] flash_addr,
  input  wire logic [15:0] flash_dq_o,
  output logic      [15:0] flash_dq_i
);
  logic [39:0] wlog [$];
  logic [15:0] last = 16'h0000;
  logic        armed = 1'b0;

  // Chip select and write strobe rise together, so a word is armed while both are low
  // and queued for the bench when either of them rises again.
  always @(flash_ce_n or flash_we_n) begin
    if (!flash_ce_n && !flash_we_n) begin
      armed = 1'b1;
    end else if (armed) begin
      armed = 1'b0;
      wlog.push_back({flash_addr, flash_dq_o});
    end
  end

  always @(posedge flash_oe_n) begin
    last <= flash_addr[15:0] ^ 16'hC3C3;
  end

  // Any sector reads back; a released bus shows the inverse of its last word.
  assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ?
                      (flash_addr[15:0] ^ 16'hC3C3) : ~last;
endmodule : fsbd_flash_model

`default_nettype wire

//--- tb/fsbd_host_asserts.sv
// Concurrent checks on the ports of the host flash command engine.
`timescale 1ns/100ps
`default_nettype none

module fsbd_host_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_refused,
  input wire logic rsp_valid,
  input wire logic sectors_unlocked,
  input wire logic prog_done,
  input wire logic high_voltage_level,
  input wire logic bypass_mode,
  input wire logic prog_active,
  input wire logic prog_suspended,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_dq_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_refuse_pulse: assert property (
    cmd_refused |=> !cmd_refused) else $error("refusal pulse too long");
  a_rsp_pulse: assert property (
    rsp_valid |=> !rsp_valid) else $error("read pulse too long");
  a_hv_unlock: assert property (
    $rose(high_voltage_level) |-> $past(sectors_unlocked))
    else $error("voltage raised on locked sectors");
  a_hv_bypass: assert property (
    $rose(high_voltage_level) |-> bypass_mode && flash_ce_n)
    else $error("voltage raise without bypass");
  a_hv_drop: assert property (
    $fell(high_voltage_level) |-> !bypass_mode && !prog_active)
    else $error("voltage drop left bypass or program");
  a_susp_rise: assert property (
    $rose(prog_suspended) |-> prog_active) else $error("suspend without program");
  a_resume_fall: assert property (
    $fell(prog_suspended) |-> prog_active || $past(prog_done))
    else $error("resume lost program");
  a_write_drive: assert property (
    !flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n)
    else $error("write strobe without bus drive");
endmodule : fsbd_host_asserts

`default_nettype wire

//--- tb/fsbd_host_bench.sv
// Self-checking bench for the host flash command engine.
`timescale 1ns/100ps
`default_nettype none

module fsbd_host_bench
  import fsbd_pkg::*;
();
  localparam logic [23:0] B = 24'h10_0000;
  localparam logic [23:0] P = 24'h10_0123;
  logic        clock, rst_n, cmd_valid, accel_req, sectors_unlocked, prog_done;
  logic        cmd_ready, rsp_valid, cmd_refused, high_voltage_level, bypass_mode;
  logic        prog_active, prog_suspended, flash_ce_n, flash_we_n, flash_oe_n;
  logic        flash_dq_oe, refd;
  fsbd_op_e    cmd_op;
  logic [23:0] cmd_addr, flash_addr;
  logic [15:0] cmd_data, rsp_data, flash_dq_o, flash_dq_i, rd;
  int          bad_count, compares;

  fsbd_host i_fsbd_host (.clock, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
    .cmd_data, .rsp_valid, .rsp_data, .cmd_refused, .accel_req, .sectors_unlocked,
    .prog_done, .high_voltage_level, .bypass_mode, .prog_active, .prog_suspended,
    .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr, .flash_dq_o, .flash_dq_oe,
    .flash_dq_i);
  fsbd_flash_model i_fsbd_flash_model (.flash_ce_n, .flash_we_n, .flash_oe_n,
    .flash_addr, .flash_dq_o, .flash_dq_i);

  task automatic summarize;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stall;
    bad_count++;
    summarize();
  endtask : stall

  task automatic chk_w(input logic [23:0] a, input logic [15:0] d);
    logic [39:0] e;
    e = 40'h00_0000_0000;
    if (i_fsbd_flash_model.wlog.size() > 0) e = i_fsbd_flash_model.wlog.pop_front();
    chk(e, {a, d});
  endtask : chk_w

  // Holds the request until an edge with cmd_ready high, then waits for the answer.
  task automatic cmd(input fsbd_op_e op, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    do begin
      @(negedge clock);
      n++;
      if (n > 200) stall();
    end while (!cmd_ready);
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
    refd = cmd_refused;
    while (op == FSBD_OP_READ ? !rsp_valid : !cmd_ready) begin
      @(negedge clock);
      n++;
      if (n > 200) stall();
    end
    rd = rsp_data;
  endtask : cmd

  task automatic pdone;
    @(posedge clock);
    prog_done <= 1'b1;
    @(posedge clock);
    prog_done <= 1'b0;
    @(negedge clock);
  endtask : pdone

  task automatic wait_hv(input logic v);
    int n;
    for (n = 0; high_voltage_level !== v; n++) begin
      if (n > 50) stall();
      @(negedge clock);
    end
  endtask : wait_hv

  task automatic t_entry;
    cmd(FSBD_OP_BYP_ENTER, B, 16'h0000);
    chk_w(B + 24'h00_0555, 16'h00AA);
    chk_w(B + 24'h00_02AA, 16'h0055);
    chk_w(B + 24'h00_0555, 16'h0020);
    chk(bypass_mode, 1'b1);
    $display("t_entry done");
  endtask : t_entry

  task automatic t_suspend;
    cmd(FSBD_OP_BYP_PROG, P, 16'hBEEF);
    chk_w(P, 16'h00A0);
    chk_w(P, 16'hBEEF);
    chk(prog_active, 1'b1);
    cmd(FSBD_OP_SUSPEND, P, 16'h0000);
    chk_w(P, 16'h00B0);
    chk(prog_suspended, 1'b1);
    cmd(FSBD_OP_READ, 24'h20_0040, 16'h0000);
    chk(rd, 16'h0040 ^ 16'hC3C3);
    cmd(FSBD_OP_RESUME, P, 16'h0000);
    chk_w(P, 16'h0030);
    chk(prog_suspended, 1'b0);
    cmd(FSBD_OP_RESUME, P, 16'h0000);
    chk(refd, 1'b1);
    chk(i_fsbd_flash_model.wlog.size(), 0);
    cmd(FSBD_OP_SUSPEND, P, 16'h0000);
    chk_w(P, 16'h00B0);
    cmd(FSBD_OP_RESUME, P, 16'h0000);
    chk_w(P, 16'h0030);
    pdone();
    chk(prog_active, 1'b0);
    $display("t_suspend done");
  endtask : t_suspend

  task automatic t_abort_exit;
    cmd(FSBD_OP_BYP_ENTER, B, 16'h0000);
    chk(refd, 1'b1);
    chk(bypass_mode, 1'b1);
    cmd(FSBD_OP_ABORT_RESET, B, 16'h0000);
    chk_w(B + 24'h00_0555, 16'h00AA);
    chk_w(B + 24'h00_02AA, 16'h0055);
    chk_w(B + 24'h00_0555, 16'h00F0);
    cmd(FSBD_OP_BYP_EXIT, B, 16'h0000);
    chk_w(B, 16'h0090);
    chk_w(B, 16'h0000);
    chk(bypass_mode, 1'b0);
    cmd(FSBD_OP_BYP_PROG, P, 16'h0001);
    chk(refd, 1'b1);
    $display("t_abort_exit done");
  endtask : t_abort_exit

  task automatic t_accel;
    @(posedge clock);
    sectors_unlocked <= 1'b1;
    accel_req <= 1'b1;
    wait_hv(1'b1);
    chk(bypass_mode, 1'b1);
    chk(i_fsbd_flash_model.wlog.size(), 0);
    for (int i = 0; i < 11; i++) begin
      cmd(FSBD_OP_BYP_PROG, P, 16'h1000 + 16'(i));
      chk(refd, i == 10);
      if (!refd) pdone();
      i_fsbd_flash_model.wlog.delete();
    end
    cmd(FSBD_OP_BYP_EXIT, B, 16'h0000);
    chk(refd, 1'b1);
    @(posedge clock);
    accel_req <= 1'b0;
    wait_hv(1'b0);
    chk(bypass_mode, 1'b0);
    $display("t_accel done");
  endtask : t_accel

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = FSBD_OP_READ;
    cmd_addr = 24'h00_0000;
    cmd_data = 16'h0000;
    accel_req = 1'b0;
    sectors_unlocked = 1'b0;
    prog_done = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_entry();
    t_suspend();
    t_abort_exit();
    t_entry();
    cmd(FSBD_OP_BYP_EXIT, B, 16'h0000);
    i_fsbd_flash_model.wlog.delete();
    t_accel();
    summarize();
  end
endmodule : fsbd_host_bench

bind fsbd_host fsbd_host_asserts i_fsbd_host_asserts (.clock, .rst_n, .cmd_refused,
  .rsp_valid, .sectors_unlocked, .prog_done, .high_voltage_level, .bypass_mode,
  .prog_active, .prog_suspended, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_dq_oe);

`default_nettype wire
